// [design/tws_consts.vh]
/*
 * constants of the two-wire master-transmitter control block:
 * register indices, control bit positions, status codes, reset values.
 * assumes nothing; definitions only.
 */
`ifndef TWS_CONSTS_VH
`define TWS_CONSTS_VH

// register indices on the bus (8-bit data, one register per address)
`define TWS_IDX_CONTROL 3'h0
`define TWS_IDX_STATUS 3'h1
`define TWS_IDX_DATA 3'h2
`define TWS_IDX_RATE 3'h3
`define TWS_IDX_MODE 3'h4

// control register bit positions
`define TWS_CR_STEP_DONE 7
`define TWS_CR_ACK_ENABLE 6
`define TWS_CR_BEGIN_REQ 5
`define TWS_CR_END_REQ 4
`define TWS_CR_COLLISION 3
`define TWS_CR_ENABLE 2
`define TWS_CR_RESERVED 1
`define TWS_CR_IRQ_ENABLE 0

// status register: code in bits 7..3, prescaler in bits 1..0
`define TWS_STATUS_MASK 8'hF8
`define TWS_PRESC_MASK 8'h03

// status codes, bus-owner send
`define TWS_CODE_IDLE 8'hF8
`define TWS_CODE_START 8'h08
`define TWS_CODE_RESTART 8'h10
`define TWS_CODE_ADDR_ACK 8'h18
`define TWS_CODE_ADDR_NACK 8'h20
`define TWS_CODE_DATA_ACK 8'h28
`define TWS_CODE_DATA_NACK 8'h30
`define TWS_CODE_ARB_LOST 8'h38

// reset values
`define TWS_RATE_RST 8'h0A
`define TWS_MODE_RST 8'h03

// current mode encodings on mode_o
`define TWS_MODE_NONE 2'h0
`define TWS_MODE_OWNER_SEND 2'h1
`define TWS_MODE_OWNER_RECV 2'h2

`endif

// [design/tws_master_tx.v]
/*
 * two-wire serial master-transmitter control with a classic wishbone
 * slave (8-bit data). drives open-drain scl/sda as output + enable.
 * assumes scl_i/sda_i are the resolved wire levels from outside the clock
 * domain, and that the wishbone master holds its request until ack.
 */
`timescale 1ns/10ps
`include "tws_consts.vh"
module tws_master_tx #(
    parameter RECV_ADDR_ACK_CODE = 8'hE0, // arbitrary code: read address acked
    parameter RECV_ADDR_NACK_CODE = 8'hE8 // arbitrary code: read address not acked
) (
    input wire clk_i,
    input wire rst_i,
    input wire wb_cyc_i,
    input wire wb_stb_i,
    input wire wb_we_i,
    input wire [2:0] wb_adr_i,
    input wire [7:0] wb_dat_i,
    output reg [7:0] wb_dat_o,
    output reg wb_ack_o,
    input wire scl_i,
    output reg scl_o,
    output reg scl_oe_o,
    input wire sda_i,
    output reg sda_o,
    output reg sda_oe_o,
    output reg [1:0] mode_o
);
    // fsm state codes
    localparam ST_IDLE = 4'h0;
    localparam ST_WAIT_FREE = 4'h1;
    localparam ST_RS_REL = 4'h2;
    localparam ST_RS_HIGH = 4'h3;
    localparam ST_START = 4'h4;
    localparam ST_START_LOW = 4'h5;
    localparam ST_BIT_LOW = 4'h6;
    localparam ST_BIT_HIGH = 4'h7;
    localparam ST_BIT_SAMP = 4'h8;
    localparam ST_HOLD = 4'h9;
    localparam ST_STOP_LOW = 4'hA;
    localparam ST_STOP_HIGH = 4'hB;
    localparam ST_STOP_REL = 4'hC;
    localparam ACK_SLOT = 4'h8; // bit counter value of the ack bit

    wire scl_s; // synchronised scl level
    wire sda_s; // synchronised sda level
    reg sda_d; // sda one cycle back, for start/stop detection
    reg bus_busy; // a start was seen and no stop yet

    // bus-side registers
    reg [7:0] data_reg; // byte to send next
    reg [7:0] rate_reg; // quarter-bit divider value
    reg [1:0] presc; // prescaler bits of the status register
    reg [3:0] mode_permit; // owner send, owner recv, addr send, addr recv
    reg collision; // write collision flag

    // control state kept beside the fsm, single writer
    reg step_done;
    reg ack_enable;
    reg begin_req;
    reg end_req;
    reg enable;
    reg irq_enable;
    reg [7:0] code; // status code, low three bits zero

    reg [3:0] state;
    reg [3:0] bit_cnt; // 0..7 data bits, 8 the ack slot
    reg [7:0] tx_byte; // shift register, msb first
    reg addr_phase; // next byte is the address byte
    reg owned; // this unit holds the bus
    reg [13:0] div_cnt; // quarter-bit divider
    reg tick; // one-cycle quarter-bit enable

    wire bus_req; // a request is pending this cycle
    wire ctrl_wr; // control register written this cycle
    wire [13:0] div_limit;

    assign bus_req = wb_cyc_i & wb_stb_i & ~wb_ack_o;
    assign ctrl_wr = bus_req & wb_we_i & (wb_adr_i == `TWS_IDX_CONTROL);
    // prescaler multiplies the quarter-bit divider limit by 1, 4, 16 or 64
    assign div_limit = {6'h00, rate_reg} << {presc, 1'b0};

    // pin levels cross into the clock domain through two flops
    tws_sync #(
        .WIDTH(2)
    ) u_sync (
        .clk_i(clk_i),
        .rst_i(rst_i),
        .d_i({scl_i, sda_i}),
        .q_o({scl_s, sda_s})
    );

    // bus-free detection: start = sda falls with scl high, stop = sda rises
    always @(posedge clk_i)
    begin
        if (rst_i)
        begin
            sda_d <= 1'b1;
            bus_busy <= 1'b0;
        end
        else
        begin
            sda_d <= sda_s;
            if (scl_s & sda_d & ~sda_s)
                bus_busy <= 1'b1; // start seen
            else if (scl_s & ~sda_d & sda_s)
                bus_busy <= 1'b0; // stop seen
        end
    end

    // quarter-bit divider; free-running so each timed state advances on tick; idle and hold do not wait for it
    always @(posedge clk_i)
    begin
        if (rst_i)
        begin
            div_cnt <= 14'h0000;
            tick <= 1'b0;
        end
        else if (div_cnt >= div_limit)
        begin
            div_cnt <= 14'h0000;
            tick <= 1'b1;
        end
        else
        begin
            div_cnt <= div_cnt + 14'h0001;
            tick <= 1'b0;
        end
    end

    // wishbone slave: ack one cycle after the request, dropped next cycle
    always @(posedge clk_i)
    begin
        if (rst_i)
        begin
            wb_ack_o <= 1'b0;
            wb_dat_o <= 8'h00;
            data_reg <= 8'hFF;
            rate_reg <= `TWS_RATE_RST;
            presc <= 2'h0;
            mode_permit <= 4'h3;
            collision <= 1'b0;
        end
        else
        begin
            wb_ack_o <= bus_req;
            if (bus_req & wb_we_i)
            begin
                case (wb_adr_i)
                    `TWS_IDX_DATA:
                    begin
                        if (step_done)
                        begin
                            data_reg <= wb_dat_i;
                            collision <= 1'b0; // a legal write clears it
                        end
                        else
                            collision <= 1'b1;
                    end
                    `TWS_IDX_STATUS: presc <= wb_dat_i[1:0];
                    `TWS_IDX_RATE: rate_reg <= wb_dat_i;
                    `TWS_IDX_MODE: mode_permit <= wb_dat_i[3:0];
                    default: ; // control handled by the fsm, others ignored
                endcase
            end
            if (bus_req & ~wb_we_i)
            begin
                case (wb_adr_i)
                    `TWS_IDX_CONTROL: wb_dat_o <= {step_done, ack_enable, begin_req,
                        end_req, collision, enable, 1'b0, irq_enable};
                    `TWS_IDX_STATUS: wb_dat_o <= (code & `TWS_STATUS_MASK)
                        | {6'h00, presc};
                    `TWS_IDX_DATA: wb_dat_o <= data_reg;
                    `TWS_IDX_RATE: wb_dat_o <= rate_reg;
                    `TWS_IDX_MODE: wb_dat_o <= {4'h0, mode_permit};
                    default: wb_dat_o <= 8'h00; // unmapped reads as zero
                endcase
            end
        end
    end

    // control register and the bus sequencer share one process so that
    // a hardware set and a software clear of one bit never race
    always @(posedge clk_i)
    begin
        if (rst_i)
        begin
            step_done <= 1'b0;
            ack_enable <= 1'b0;
            begin_req <= 1'b0;
            end_req <= 1'b0;
            enable <= 1'b0;
            irq_enable <= 1'b0;
            code <= `TWS_CODE_IDLE;
            state <= ST_IDLE;
            bit_cnt <= 4'h0;
            tx_byte <= 8'hFF;
            addr_phase <= 1'b0;
            owned <= 1'b0;
            scl_o <= 1'b0;
            sda_o <= 1'b0;
            scl_oe_o <= 1'b0;
            sda_oe_o <= 1'b0;
            mode_o <= `TWS_MODE_NONE;
        end
        else
        begin
            // software side of the control register
            if (ctrl_wr)
            begin
                ack_enable <= wb_dat_i[`TWS_CR_ACK_ENABLE];
                begin_req <= wb_dat_i[`TWS_CR_BEGIN_REQ];
                end_req <= wb_dat_i[`TWS_CR_END_REQ];
                enable <= wb_dat_i[`TWS_CR_ENABLE];
                irq_enable <= wb_dat_i[`TWS_CR_IRQ_ENABLE];
                if (wb_dat_i[`TWS_CR_STEP_DONE])
                    step_done <= 1'b0;
            end
            if (~enable)
            begin
                // disabled: release both lines and forget the bus
                state <= ST_IDLE;
                scl_oe_o <= 1'b0;
                sda_oe_o <= 1'b0;
                owned <= 1'b0;
                mode_o <= `TWS_MODE_NONE;
            end
            else
            begin
                case (state)
                    ST_IDLE:
                    begin
                        // owner modes must be permitted by software
                        if (begin_req & (mode_permit[0] | mode_permit[1]))
                            state <= ST_WAIT_FREE;
                    end
                    ST_WAIT_FREE:
                    begin
                        // both lines high and no foreign start pending
                        if (tick & ~bus_busy & scl_s & sda_s)
                            state <= ST_START;
                    end
                    ST_RS_REL:
                    begin
                        // repeated start: free sda while scl is still low
                        if (tick)
                        begin
                            sda_oe_o <= 1'b0;
                            state <= ST_RS_HIGH;
                        end
                    end
                    ST_RS_HIGH:
                    begin
                        scl_oe_o <= 1'b0;
                        // waiting on scl_s also honours clock stretching
                        if (tick & scl_s)
                            state <= ST_START;
                    end
                    ST_START:
                    begin
                        if (tick)
                        begin
                            sda_oe_o <= 1'b1; // sda falls with scl high
                            state <= ST_START_LOW;
                        end
                    end
                    ST_START_LOW:
                    begin
                        if (tick)
                        begin
                            scl_oe_o <= 1'b1;
                            code <= owned ? `TWS_CODE_RESTART : `TWS_CODE_START;
                            step_done <= 1'b1;
                            owned <= 1'b1;
                            addr_phase <= 1'b1;
                            state <= ST_HOLD;
                        end
                    end
                    ST_BIT_LOW:
                    begin
                        if (tick)
                        begin
                            scl_oe_o <= 1'b1;
                            // a one is a released line, a zero pulled low
                            if (bit_cnt == ACK_SLOT)
                                sda_oe_o <= 1'b0;
                            else
                                sda_oe_o <= ~tx_byte[7];
                            state <= ST_BIT_HIGH;
                        end
                    end
                    ST_BIT_HIGH:
                    begin
                        scl_oe_o <= 1'b0;
                        if (tick & scl_s)
                            state <= ST_BIT_SAMP;
                    end
                    ST_BIT_SAMP:
                    begin
                        if (tick)
                        begin
                            if (bit_cnt != ACK_SLOT)
                            begin
                                if (tx_byte[7] & ~sda_s)
                                begin
                                    // someone else pulled low: arbitration lost
                                    scl_oe_o <= 1'b0;
                                    sda_oe_o <= 1'b0;
                                    owned <= 1'b0;
                                    mode_o <= `TWS_MODE_NONE;
                                    code <= `TWS_CODE_ARB_LOST;
                                    step_done <= 1'b1;
                                    state <= ST_HOLD;
                                end
                                else
                                begin
                                    scl_oe_o <= 1'b1;
                                    tx_byte <= {tx_byte[6:0], 1'b1};
                                    bit_cnt <= bit_cnt + 4'h1;
                                    state <= ST_BIT_LOW;
                                end
                            end
                            else
                            begin
                                // ack slot: low is ack, high is not-ack
                                scl_oe_o <= 1'b1;
                                step_done <= 1'b1;
                                addr_phase <= 1'b0;
                                if (addr_phase & (mode_o == `TWS_MODE_OWNER_RECV))
                                    code <= sda_s ? RECV_ADDR_NACK_CODE : RECV_ADDR_ACK_CODE;
                                else if (addr_phase)
                                    code <= sda_s ? `TWS_CODE_ADDR_NACK
                                        : `TWS_CODE_ADDR_ACK;
                                else
                                    code <= sda_s ? `TWS_CODE_DATA_NACK
                                        : `TWS_CODE_DATA_ACK;
                                state <= ST_HOLD;
                            end
                        end
                    end
                    ST_HOLD:
                    begin
                        // scl stays low while the flag is up; after a lost arbitration it is left released
                        if (~step_done)
                        begin
                            if (~owned)
                                // after a lost arbitration: retry or release
                                state <= begin_req ? ST_WAIT_FREE : ST_IDLE;
                            else if (end_req)
                                state <= ST_STOP_LOW;
                            else if (begin_req)
                                state <= ST_RS_REL;
                            else if (addr_phase | (mode_o == `TWS_MODE_OWNER_SEND))
                            begin
                                // send the loaded byte; the address bit
                                // picks the owner direction
                                tx_byte <= data_reg;
                                bit_cnt <= 4'h0;
                                if (addr_phase)
                                    mode_o <= data_reg[0] ? `TWS_MODE_OWNER_RECV
                                        : `TWS_MODE_OWNER_SEND;
                                state <= ST_BIT_LOW;
                            end
                            // receive data phase is not built: stays here
                        end
                    end
                    ST_STOP_LOW:
                    begin
                        if (tick)
                        begin
                            sda_oe_o <= 1'b1; // sda low under low scl
                            state <= ST_STOP_HIGH;
                        end
                    end
                    ST_STOP_HIGH:
                    begin
                        scl_oe_o <= 1'b0;
                        if (tick & scl_s)
                            state <= ST_STOP_REL;
                    end
                    ST_STOP_REL:
                    begin
                        if (tick)
                        begin
                            sda_oe_o <= 1'b0; // sda rises with scl high
                            end_req <= 1'b0;
                            owned <= 1'b0;
                            mode_o <= `TWS_MODE_NONE;
                            code <= `TWS_CODE_IDLE;
                            // stop then start when both were requested
                            state <= begin_req ? ST_WAIT_FREE : ST_IDLE;
                        end
                    end
                    default: state <= ST_IDLE;
                endcase
            end
        end
    end
endmodule

// [design/tws_sync.v]
/*
 * two flip-flop synchroniser, WIDTH bits wide.
 * assumes each bit is an independent level; no word coherence across bits.
 */
`timescale 1ns/10ps
module tws_sync #(
    parameter WIDTH = 1
) (
    input wire clk_i,
    input wire rst_i,
    input wire [WIDTH-1:0] d_i,
    output wire [WIDTH-1:0] q_o
);
    reg [WIDTH-1:0] meta; // first stage, read only by the second stage
    reg [WIDTH-1:0] stable; // second stage, safe to use

    // both stages reset high: an idle open-drain line reads high
    always @(posedge clk_i)
    begin
        if (rst_i)
        begin
            meta <= {WIDTH{1'b1}};
            stable <= {WIDTH{1'b1}};
        end
        else
        begin
            meta <= d_i;
            stable <= meta;
        end
    end

    assign q_o = stable;
endmodule

// [sim/testbench.sv]
/*
 * self-checking bench: software sequences over wishbone, slave model beyond.
 * assumes one bus request at a time and the pull-ups modelled here.
 */
`timescale 1ns/10ps
`include "tws_consts.vh"
module testbench;
    reg clk_i, rst_i, cyc, stb, we, s_ack;
    reg [2:0] adr;
    reg [7:0] wdat;
    reg [31:0] rnd = 32'd86; // xorshift state
    reg [15:0] rd_q[$]; // {mask, expected} per read
    reg [7:0] by_q[$]; // bytes the slave should see
    reg [15:0] e, m; // e for the driver, m for the monitor, so neither clobbers the other
    reg [7:0] q;
    integer errors = 0, checks = 0, i;
    wire [7:0] rdat, s_byte;
    wire ack, scl_o, scl_oe, sda_o, sda_oe, s_oe, got;
    wire [1:0] mode;
    wire scl_w = scl_oe ? scl_o : 1'b1; // pull-up when released
    wire sda_w = (sda_oe ? sda_o : 1'b1) & ~s_oe;
    tws_master_tx u_dut (.clk_i(clk_i), .rst_i(rst_i), .wb_cyc_i(cyc), .wb_stb_i(stb),
        .wb_we_i(we), .wb_adr_i(adr), .wb_dat_i(wdat), .wb_dat_o(rdat), .wb_ack_o(ack),
        .scl_i(scl_w), .scl_o(scl_o), .scl_oe_o(scl_oe), .sda_i(sda_w), .sda_o(sda_o),
        .sda_oe_o(sda_oe), .mode_o(mode));
    tws_slave_model u_slv (.scl_i(scl_w), .sda_i(sda_w), .ack_i(s_ack), .sda_oe_o(s_oe),
        .byte_o(s_byte), .got_o(got));
    initial
    begin
        clk_i = 1'b0;
        forever #5 clk_i = ~clk_i;
    end
    function automatic [31:0] xorshift();
        rnd = rnd ^ (rnd << 13);
        rnd = rnd ^ (rnd >> 17);
        rnd = rnd ^ (rnd << 5);
        xorshift = rnd;
    endfunction
    task automatic cmp(input [7:0] g, input [7:0] x);
        checks = checks + 1;
        if (g !== x)
        begin
            errors = errors + 1;
            $display("[FAIL] t=%0t got %h exp %h", $time, g, x);
        end
    endtask
    task results;
        if (errors == 0 && checks > 0)
            $display("ALL CHECKS OK");
        else
            $display("CHECKS NOT OK");
        $finish;
    endtask
    // one classic cycle: hold everything until ack is sampled high
    task automatic bus(input [2:0] a, input w, input [7:0] d, input [15:0] c);
        integer n;
        cyc <= 1'b1;
        stb <= 1'b1;
        we <= w;
        adr <= a;
        wdat <= d;
        if (!w)
            rd_q.push_back(c);
        n = 0;
        @(posedge clk_i);
        while (ack !== 1'b1 && n < 50)
        begin
            @(posedge clk_i);
            n = n + 1;
        end
        q = rdat;
        if (n >= 50)
        begin
            errors = errors + 1;
            results();
        end
        cyc <= 1'b0;
        stb <= 1'b0;
        @(posedge clk_i);
    endtask
    // poll the control register until one bit reaches a level, bounded
    task automatic poll(input integer b, input v);
        integer n;
        q = ~{8{v}};
        for (n = 0; q[b] !== v; n = n + 1)
        begin
            if (n > 400)
            begin
                errors = errors + 1;
                results();
            end
            bus(`TWS_IDX_CONTROL, 1'b0, 8'h00, 16'h0000);
        end
    endtask
    // one packet sequence after a start request; ends with command end_cmd
    task automatic xfer(input [7:0] code0, input [7:0] end_cmd);
        integer k, nb;
        reg [31:0] r;
        poll(`TWS_CR_STEP_DONE, 1'b1);
        bus(1, 0, 0, {`TWS_STATUS_MASK, code0});
        nb = 1 + xorshift() % 3;
        for (k = 0; k <= nb; k = k + 1)
        begin
            r = xorshift();
            s_ack <= r[8]; // slave answers ack or not-ack
            q = (k == 0) ? {r[7:1], 1'b0} : r[7:0]; // address carries the write bit
            by_q.push_back(q);
            bus(`TWS_IDX_DATA, 1'b1, q, 0);
            bus(`TWS_IDX_CONTROL, 1'b1, 8'h84, 0);
            poll(`TWS_CR_STEP_DONE, 1'b1);
            if (k == 0)
                cmp({6'h00, mode}, {6'h00, `TWS_MODE_OWNER_SEND});
            e[7:0] = k == 0 ? (r[8] ? `TWS_CODE_ADDR_ACK : `TWS_CODE_ADDR_NACK)
                : (r[8] ? `TWS_CODE_DATA_ACK : `TWS_CODE_DATA_NACK);
            bus(1, 0, 0, {`TWS_STATUS_MASK, e[7:0]});
        end
        bus(`TWS_IDX_CONTROL, 1'b1, end_cmd, 0);
    endtask
    // second process: oldest noted result against each read that completes
    always @(posedge clk_i)
    begin
        if (ack === 1'b1 && we === 1'b0 && rd_q.size() > 0)
        begin
            m = rd_q.pop_front();
            if (m[15:8] != 8'h00)
                cmp(rdat & m[15:8], m[7:0]);
        end
    end
    always @(got)
    begin
        if (by_q.size() > 0)
            cmp(s_byte, by_q.pop_front());
    end
    initial
    begin
        rst_i <= 1'b1;
        {cyc, stb, we, s_ack} <= 4'h0;
        adr <= 3'h0;
        wdat <= 8'h00;
        repeat (12) @(posedge clk_i);
        rst_i <= 1'b0;
        @(posedge clk_i);
        // reset values, then unmapped indices read as zero
        for (i = 0; i < 7; i = i + 1)
            bus(i, 0, 0, {8'hFF, 8'(56'h0000030AFFF800 >> (8 * i))});
        bus(`TWS_IDX_CONTROL, 1'b1, 8'h08, 0); // collision bit is read-only
        bus(`TWS_IDX_CONTROL, 1'b0, 0, 16'hFF00);
        bus(`TWS_IDX_RATE, 1'b1, 8'h01, 0); // 80 ns bit time
        bus(`TWS_IDX_STATUS, 1'b1, 8'h00, 0);
        bus(`TWS_IDX_CONTROL, 1'b1, 8'h04, 0);
        bus(`TWS_IDX_DATA, 1'b1, 8'h55, 0);
        bus(`TWS_IDX_CONTROL, 1'b0, 0, 16'h0808);
        bus(`TWS_IDX_DATA, 1'b0, 0, 16'hFFFF);
        bus(`TWS_IDX_CONTROL, 1'b1, 8'hA4, 0);
        xfer(`TWS_CODE_START, 8'hA4);
        xfer(`TWS_CODE_RESTART, 8'h94);
        poll(`TWS_CR_END_REQ, 1'b0);
        bus(`TWS_IDX_CONTROL, 1'b0, 0, 16'h1000);
        bus(`TWS_IDX_CONTROL, 1'b1, 8'hA4, 0);
        poll(`TWS_CR_STEP_DONE, 1'b1);
        bus(1, 0, 0, {`TWS_STATUS_MASK, `TWS_CODE_START});
        // address with the read bit: the unit must pick owner receive
        q = 8'(xorshift()) | 8'h01;
        s_ack <= 1'b1;
        by_q.push_back(q);
        bus(`TWS_IDX_DATA, 1'b1, q, 0);
        bus(`TWS_IDX_CONTROL, 1'b1, 8'h84, 0);
        poll(`TWS_CR_STEP_DONE, 1'b1);
        cmp({6'h00, mode}, {6'h00, `TWS_MODE_OWNER_RECV});
        bus(`TWS_IDX_CONTROL, 1'b1, 8'h00, 0);
        bus(`TWS_IDX_CONTROL, 1'b0, 0, 16'h0400);
        repeat (4) @(posedge clk_i);
        cmp({6'h00, mode}, {6'h00, `TWS_MODE_NONE});
        // every byte handed to the unit must have reached the slave
        cmp(8'(by_q.size()), 8'h00);
        results();
    end
endmodule

// [sim/tws_master_tx_checker.sv]
/*
 * concurrent checks on the master-transmitter ports.
 * assumes the rate register is set small before any transfer starts.
 */
`timescale 1ns/10ps
`include "tws_consts.vh"
module tws_master_tx_checker (
    input wire clk_i,
    input wire rst_i,
    input wire wb_cyc_i,
    input wire wb_stb_i,
    input wire wb_we_i,
    input wire [2:0] wb_adr_i,
    input wire [7:0] wb_dat_i,
    input wire [7:0] wb_dat_o,
    input wire wb_ack_o,
    input wire scl_i,
    input wire scl_o,
    input wire scl_oe_o,
    input wire sda_i,
    input wire sda_o,
    input wire sda_oe_o,
    input wire [1:0] mode_o
);
    default clocking cb @(posedge clk_i); endclocking
    default disable iff (rst_i);
    wire req = wb_cyc_i && wb_stb_i && !wb_ack_o; // request taken this edge
    reg [4:0] quiet; // cycles since a register write, saturating
    reg [4:0] low_run; // cycles the unit has held the clock low
    // a long low clock may only end shortly after software wrote
    always @(posedge clk_i)
    begin
        if (rst_i)
        begin
            quiet <= 5'h1F;
            low_run <= 5'h00;
        end
        else
        begin
            quiet <= (req && wb_we_i) ? 5'h00 : quiet + {4'h0, quiet != 5'h1F};
            low_run <= scl_oe_o ? low_run + {4'h0, low_run != 5'h1F} : 5'h00;
        end
    end
    a_ack_next_cycle: assert property (req |=> wb_ack_o) else $error("ack late");
    a_ack_one_pulse: assert property (wb_ack_o |=> !wb_ack_o) else $error("ack held");
    a_no_stray_ack: assert property (!(wb_cyc_i && wb_stb_i) |=> !wb_ack_o)
        else $error("ack without request");
    a_start_bus_free: assert property ($rose(sda_oe_o) && !scl_oe_o |->
        $past(scl_i) && $past(sda_i)) else $error("start on busy bus");
    a_disable_releases: assert property (req && wb_we_i && wb_adr_i == `TWS_IDX_CONTROL
        && !wb_dat_i[`TWS_CR_ENABLE] |-> ##[1:3] (!scl_oe_o && !sda_oe_o
        && mode_o == `TWS_MODE_NONE)) else $error("disable did not release");
    a_hold_while_flag: assert property ($fell(scl_oe_o) |->
        ($past(low_run) < 12 || quiet < 16)) else $error("clock freed without clear");
    a_reset_quiet: assert property (disable iff (1'b0) rst_i |=> !wb_ack_o && !scl_oe_o
        && !sda_oe_o && mode_o == `TWS_MODE_NONE) else $error("reset state wrong");
    a_pins_pull_low: assert property (scl_oe_o || sda_oe_o |->
        !(scl_oe_o && scl_o) && !(sda_oe_o && sda_o)) else $error("line driven high");
endmodule
bind tws_master_tx tws_master_tx_checker u_chk (.clk_i(clk_i), .rst_i(rst_i),
    .wb_cyc_i(wb_cyc_i), .wb_stb_i(wb_stb_i), .wb_we_i(wb_we_i), .wb_adr_i(wb_adr_i),
    .wb_dat_i(wb_dat_i), .wb_dat_o(wb_dat_o), .wb_ack_o(wb_ack_o), .scl_i(scl_i),
    .scl_o(scl_o), .scl_oe_o(scl_oe_o), .sda_i(sda_i), .sda_o(sda_o),
    .sda_oe_o(sda_oe_o), .mode_o(mode_o));

// [sim/tws_slave_model.sv]
/*
 * behavioural slave receiver on the two-wire bus: frames bytes msb first
 * and answers each ninth bit with ack or not-ack as the bench commands.
 * assumes resolved wire levels with pull-ups; it never drives the clock.
 */
`timescale 1ns/10ps
module tws_slave_model (
    input wire scl_i,
    input wire sda_i,
    input wire ack_i,
    output reg sda_oe_o,
    output reg [7:0] byte_o,
    output reg got_o
);
    integer cnt; // bit slot within the current byte
    initial
    begin
        sda_oe_o = 1'b0;
        byte_o = 8'h00;
        got_o = 1'b0;
        cnt = 0;
    end
    // data moving under a high clock is a start or a stop: reframe
    always @(sda_i)
    begin
        if (scl_i === 1'b1)
            cnt = 0;
    end
    // sample on the rising clock, eight data bits then the ack slot
    always @(posedge scl_i)
    begin
        if (cnt < 8)
            byte_o = {byte_o[6:0], sda_i};
        cnt = cnt + 1;
    end
    // drive the answer from the falling clock after bit eight, release on the falling clock that ends the slot
    always @(negedge scl_i)
    begin
        if (cnt == 8)
            sda_oe_o = ack_i;
        else if (cnt == 9)
        begin
            sda_oe_o = 1'b0; // released line floats back high
            cnt = 0;
            got_o = ~got_o; // one toggle per whole byte
        end
    end
endmodule
